/* File: inc/ebio_pkg.sv */
package ebio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int BANKS = 8;
  localparam int BANK_W = 8;
  localparam int EXT_W = BANKS * BANK_W;
  localparam int STD_W = 8;
  localparam int PAIRS = BANKS / 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PT_W = 7;
  localparam int BIDX_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WORD0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WORD3 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SET = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CLR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ASG = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_BIDX = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BIN = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_BVAR = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_PIDX = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_PIN = 8'h34;

  // ----------------------------------------------------------------
  // Fields, point numbering and reset values
  // ----------------------------------------------------------------
  localparam int ASG_VAL_BIT = 8;
  localparam logic [PT_W-1:0] PT_STD_FIRST = 7'h01;
  localparam logic [PT_W-1:0] PT_STD_LAST = 7'h08;
  localparam logic [PT_W-1:0] PT_EXT_FIRST = 7'h11;
  localparam logic [PT_W-1:0] PT_EXT_LAST = 7'h50;
  localparam logic [BIDX_W-1:0] BANK_SEL_OFS = 4'h2;
  localparam logic [BANK_W-1:0] CFG_RST = 8'h00;
  localparam logic [STD_W-1:0] STD_RST = 8'h00;
  localparam logic [EXT_W-1:0] EXT_RST = 64'h0;
  localparam logic [BIDX_W-1:0] BIDX_RST = 4'h2;
  localparam logic [PT_W-1:0] PIDX_RST = 7'h11;

  typedef enum logic [1:0] {
    EBIO_IDLE = 2'b00,
    EBIO_ACK = 2'b01
  } ebio_state_t;

endpackage

/* File: logic/ebio_bank_io.sv */
`timescale 1ns/10ps
module ebio_bank_io
  import ebio_pkg::*;
(
  input wire logic [BANKS-1:0] cfg,
  input wire logic [EXT_W-1:0] extLatch,
  input wire logic [EXT_W-1:0] extIn,
  input wire logic [BIDX_W-1:0] bankIdx,
  output logic [EXT_W-1:0] extOut,
  output logic [EXT_W-1:0] extOe,
  output logic [BANK_W-1:0] bankVal
);

  logic [BANK_W-1:0] bankPick [BANKS];

  // -----------------------------------------------------------------
  // Per-bank pin drive and input selection
  // -----------------------------------------------------------------
  // An input bank drives low data so nothing fights the field side.
  for (genvar k = 0; k < BANKS; k++) begin : gBank
    assign extOe[k*BANK_W +: BANK_W] = {BANK_W{cfg[k]}};
    assign extOut[k*BANK_W +: BANK_W] =
      extLatch[k*BANK_W +: BANK_W] & {BANK_W{cfg[k]}};
    assign bankPick[k] =
      (bankIdx == BANK_SEL_OFS + BIDX_W'(k)) ?
      extIn[k*BANK_W +: BANK_W] : '0;
  end

  // Only one bank can match, so an OR of the picks is the mux.
  always_comb begin
    bankVal = '0;
    for (int k = 0; k < BANKS; k++) begin
      bankVal = bankVal | bankPick[k];
    end
  end

endmodule

/* File: logic/ebio_point_decode.sv */
`timescale 1ns/10ps
module ebio_point_decode
  import ebio_pkg::*;
(
  input wire logic [PT_W-1:0] pointNum,
  output logic isStd,
  output logic isExt,
  output logic [5:0] extIdx,
  output logic [2:0] stdIdx
);

  logic [PT_W-1:0] extOff;
  logic [PT_W-1:0] stdOff;

  // Points 17 to 80 map onto the bank bits consecutively.
  always_comb begin
    isStd = (pointNum >= PT_STD_FIRST) && (pointNum <= PT_STD_LAST);
    isExt = (pointNum >= PT_EXT_FIRST) && (pointNum <= PT_EXT_LAST);
    extOff = pointNum - PT_EXT_FIRST;
    stdOff = pointNum - PT_STD_FIRST;
    extIdx = extOff[5:0];
    stdIdx = stdOff[2:0];
  end

endmodule

/* File: logic/ebio_top.sv */
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module ebio_top
  import ebio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [STD_W-1:0] stdIn,
  output logic [STD_W-1:0] stdOut,
  input wire logic [EXT_W-1:0] extIn,
  output logic [EXT_W-1:0] extOut,
  output logic [EXT_W-1:0] extOe
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    ebio_state_t st;
    logic [BANKS-1:0] cfg;
    logic [STD_W-1:0] stdOut;
    logic [EXT_W-1:0] ext;
    logic [BIDX_W-1:0] bankIdx;
    logic [PT_W-1:0] pointIdx;
    logic [BANK_W-1:0] bankVar;
    logic pointBit;
    logic [DATA_W-1:0] rdata;
  } ebio_regs_t;

  ebio_regs_t r_reg;
  ebio_regs_t r_next;

  logic req;
  logic accept;
  logic wrStd;
  logic wrExt;
  logic [5:0] wrExtIdx;
  logic [2:0] wrStdIdx;
  logic rdStd;
  logic rdExt;
  logic [5:0] rdExtIdx;
  logic [2:0] rdStdIdx;
  logic [BANK_W-1:0] bankVal;
  logic [ADDR_W-1:0] wordOff;
  logic [1:0] pairSel;
  logic isCmd;
  logic cmdVal;
  logic cmdHit;

  // -----------------------------------------------------------------
  // Point decoders for commands and for the single-point read
  // -----------------------------------------------------------------
  ebio_point_decode uWrPt (
    .pointNum(avs_writedata[PT_W-1:0]),
    .isStd(wrStd),
    .isExt(wrExt),
    .extIdx(wrExtIdx),
    .stdIdx(wrStdIdx)
  );

  ebio_point_decode uRdPt (
    .pointNum(r_reg.pointIdx),
    .isStd(rdStd),
    .isExt(rdExt),
    .extIdx(rdExtIdx),
    .stdIdx(rdStdIdx)
  );

  ebio_bank_io uBanks (
    .cfg(r_reg.cfg),
    .extLatch(r_reg.ext),
    .extIn(extIn),
    .bankIdx(r_reg.bankIdx),
    .extOut(extOut),
    .extOe(extOe),
    .bankVal(bankVal)
  );

  // -----------------------------------------------------------------
  // Bus handshake
  // -----------------------------------------------------------------
  // Every access waits exactly one cycle; read data is set up in that
  // cycle so the mux never sits in the path to readdata.
  assign req = avs_read | avs_write;
  assign accept = req && (r_reg.st == EBIO_ACK);
  assign avs_waitrequest = req && (r_reg.st != EBIO_ACK);
  assign avs_readdata = r_reg.rdata;
  assign stdOut = r_reg.stdOut;

  // Word registers sit on a four-byte stride from the first pair.
  assign wordOff = avs_address - OFS_WORD0;
  assign pairSel = wordOff[3:2];
  assign isCmd = (avs_address == OFS_SET) ||
                 (avs_address == OFS_CLR) ||
                 (avs_address == OFS_ASG);
  // Assign takes its value from the data, set and clear are fixed.
  assign cmdVal = (avs_address == OFS_SET) ? 1'b1 :
                  (avs_address == OFS_CLR) ? 1'b0 :
                  avs_writedata[ASG_VAL_BIT];
  // A command lands on any standard point, or on an extended point of an output bank.
  assign cmdHit = (wrExt && r_reg.cfg[wrExtIdx[5:3]]) || wrStd;

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // Both bank views come from this one flop, so they never differ.
    r_next.bankVar = bankVal;
    // Raw pin level: the pull-up makes an open contact read one.
    r_next.pointBit = rdExt ? extIn[rdExtIdx] :
                      rdStd ? stdIn[rdStdIdx] : 1'b0;
    case (r_reg.st)
      EBIO_IDLE: begin
        if (req) begin
          r_next.st = EBIO_ACK;
        end
        if (avs_read) begin
          r_next.rdata = '0;
          if (avs_address == OFS_CFG) begin
            r_next.rdata[BANKS-1:0] = r_reg.cfg;
          end else if (avs_address == OFS_STD) begin
            r_next.rdata[STD_W-1:0] = r_reg.stdOut;
          end else if ((avs_address >= OFS_WORD0) &&
                       (avs_address <= OFS_WORD3) &&
                       (wordOff[1:0] == 2'b00)) begin
            r_next.rdata[2*BANK_W-1:0] =
              r_reg.ext[pairSel*2*BANK_W +: 2*BANK_W];
          end else if (avs_address == OFS_BIDX) begin
            r_next.rdata[BIDX_W-1:0] = r_reg.bankIdx;
          end else if (avs_address == OFS_BIN) begin
            r_next.rdata[BANK_W-1:0] = r_reg.bankVar;
          end else if (avs_address == OFS_BVAR) begin
            r_next.rdata[BANK_W-1:0] = r_reg.bankVar;
          end else if (avs_address == OFS_PIDX) begin
            r_next.rdata[PT_W-1:0] = r_reg.pointIdx;
          end else if (avs_address == OFS_PIN) begin
            r_next.rdata[0] = r_reg.pointBit;
          end
        end
      end
      EBIO_ACK: begin
        r_next.st = EBIO_IDLE;
        if (avs_write) begin
          if (avs_address == OFS_CFG) begin
            if (avs_byteenable[0]) begin
              r_next.cfg = avs_writedata[BANKS-1:0];
            end
          end else if (avs_address == OFS_STD) begin
            if (avs_byteenable[0]) begin
              r_next.stdOut = avs_writedata[STD_W-1:0];
            end
          end else if ((avs_address >= OFS_WORD0) &&
                       (avs_address <= OFS_WORD3) &&
                       (wordOff[1:0] == 2'b00)) begin
            // Each byte lane lands only if its bank is an output.
            for (int j = 0; j < 2; j++) begin
              if (avs_byteenable[j] && r_reg.cfg[pairSel*2+j]) begin
                r_next.ext[(pairSel*2+j)*BANK_W +: BANK_W] =
                  avs_writedata[j*BANK_W +: BANK_W];
              end
            end
          end else if (isCmd) begin
            if (avs_byteenable[0] && cmdHit) begin
              if (wrExt) begin
                r_next.ext[wrExtIdx] = cmdVal;
              end else begin
                r_next.stdOut[wrStdIdx] = cmdVal;
              end
            end
            // Any other point number leaves the pins alone.
          end else if (avs_address == OFS_BIDX) begin
            if (avs_byteenable[0]) begin
              r_next.bankIdx = avs_writedata[BIDX_W-1:0];
            end
          end else if (avs_address == OFS_PIDX) begin
            if (avs_byteenable[0]) begin
              r_next.pointIdx = avs_writedata[PT_W-1:0];
            end
          end
        end
      end
      default: begin
        r_next.st = EBIO_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  // Extended outputs start undriven-safe: every bank is an input; stdOut starts driven low.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg.st <= EBIO_IDLE;
      r_reg.cfg <= CFG_RST;
      r_reg.stdOut <= STD_RST;
      r_reg.ext <= EXT_RST;
      r_reg.bankIdx <= BIDX_RST;
      r_reg.pointIdx <= PIDX_RST;
      r_reg.bankVar <= '0;
      r_reg.pointBit <= 1'b0;
      r_reg.rdata <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cbDef @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic wrAcc;
  assign wrAcc = accept && avs_write;

  AST_CFG_LOW_BANK: assert property (
    wrAcc && avs_address == OFS_CFG && avs_byteenable[0]
    |=> extOe[BANK_W-1:0] == {BANK_W{$past(avs_writedata[0])}})
    else $error("bank 0 direction does not follow config bit 0");

  AST_CFG_TOP_BANK: assert property (
    wrAcc && avs_address == OFS_CFG && avs_byteenable[0]
    |=> extOe[EXT_W-1:EXT_W-BANK_W] ==
        {BANK_W{$past(avs_writedata[BANKS-1])}})
    else $error("bank 7 direction does not follow config bit 7");

  AST_WORD_PAIR1: assert property (
    wrAcc && avs_address == OFS_WORD0 + 8'h04 &&
    avs_byteenable[1:0] == 2'b11 && r_reg.cfg[3:2] == 2'b11
    |=> extOut[4*BANK_W-1:2*BANK_W] == $past(avs_writedata[15:0]))
    else $error("word for banks 2 and 3 not driven");

  AST_SET_BIT: assert property (
    wrAcc && avs_address == OFS_SET && avs_byteenable[0] &&
    wrExt && r_reg.cfg[wrExtIdx[5:3]]
    |=> extOut[$past(wrExtIdx)] == 1'b1)
    else $error("set request did not drive output high");

  AST_CLR_BIT: assert property (
    wrAcc && avs_address == OFS_CLR && avs_byteenable[0] &&
    wrExt && r_reg.cfg[wrExtIdx[5:3]]
    |=> extOut[$past(wrExtIdx)] == 1'b0 && $stable(stdOut))
    else $error("clear request did not drive output low");

  AST_ASG_BIT: assert property (
    wrAcc && avs_address == OFS_ASG && avs_byteenable[0] && wrStd
    |=> stdOut[$past(wrStdIdx)] == $past(avs_writedata[ASG_VAL_BIT]))
    else $error("assign request wrote the wrong value");

  // Three cycles of a steady select keep the reset value of the copy
  // out of the check, since the pins are already live at release.
  AST_BANK_READ: assert property (
    (r_reg.bankIdx == BANK_SEL_OFS) [*3]
    |-> r_reg.bankVar == $past(extIn[BANK_W-1:0]))
    else $error("bank read does not hold bank 0 inputs");

  AST_POINT_READ: assert property (
    (r_reg.pointIdx == PT_EXT_FIRST) [*3]
    |-> r_reg.pointBit == $past(extIn[0]))
    else $error("point 17 read does not follow its pin");

  AST_POINT_STD: assert property (
    (r_reg.pointIdx == PT_STD_FIRST) [*3]
    |-> r_reg.pointBit == $past(stdIn[0]))
    else $error("point 1 read does not follow its pin");

  // Point 25 must be the lowest bit of bank 1, whatever the decoder says.
  AST_EXT_MAP: assert property (
    wrAcc && avs_address == OFS_SET && avs_byteenable[0] &&
    avs_writedata[PT_W-1:0] == PT_EXT_FIRST + PT_W'(BANK_W) && r_reg.cfg[1]
    |=> extOut[BANK_W] == 1'b1)
    else $error("point 25 is not the first bit of bank 1");

  // A dropped word byte must leave the latch, not only the pins.
  AST_WORD_INPUT_DROP: assert property (
    wrAcc && avs_address == OFS_WORD0 && avs_byteenable[0] &&
    !r_reg.cfg[0]
    |=> extOut[BANK_W-1:0] == '0 && $stable(r_reg.ext[BANK_W-1:0]))
    else $error("word byte to an input bank changed its latch");

  AST_LANE_OFF_IGNORED: assert property (
    wrAcc && isCmd && !avs_byteenable[0]
    |=> $stable(extOut) && $stable(stdOut))
    else $error("command without lane 0 changed an output");

  AST_BAD_IGNORED: assert property (
    wrAcc && isCmd && !cmdHit
    |=> $stable(extOut) && $stable(stdOut))
    else $error("ignored request changed an output");

  AST_ONE_WAIT: assert property (
    req && avs_waitrequest |=> !avs_waitrequest [*1] ##1
    (!req || avs_waitrequest))
    else $error("access not answered after one wait cycle");

  COV_SET_EXT: cover property (
    wrAcc && avs_address == OFS_SET && wrExt && cmdHit);
  COV_CFG_ALL_OUT: cover property (
    wrAcc && avs_address == OFS_CFG && avs_writedata[7:0] == 8'hFF);
  COV_BANK_READ: cover property (
    accept && avs_read && avs_address == OFS_BIN);
  COV_BAD_POINT: cover property (wrAcc && isCmd && !cmdHit);
  COV_LANE_OFF: cover property (wrAcc && isCmd && !avs_byteenable[0]);

endmodule

/* File: verif/ebio_field_model.sv */
`timescale 1ns/10ps
module ebio_field_model
  import ebio_pkg::*;
(
  input wire logic [EXT_W-1:0] extOut,
  input wire logic [EXT_W-1:0] extOe,
  input wire logic [EXT_W-1:0] swClosed,
  input wire logic [STD_W-1:0] stdClosed,
  output logic [EXT_W-1:0] extIn,
  output logic [STD_W-1:0] stdIn
);
  // An open contact floats up on the pull-up and a closed one pulls low.
  // An output bank reads back its own drive, as the real pin would.
  always_comb begin
    for (int i = 0; i < EXT_W; i++) begin
      extIn[i] = extOe[i] ? extOut[i] : !swClosed[i];
    end
  end
  assign stdIn = ~stdClosed;
endmodule

/* File: verif/ebio_top_bench.sv */
`timescale 1ns/10ps
module ebio_top_bench import ebio_pkg::*;;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, expQ[$];
  logic [DATA_W-1:0] rnd;
  logic [3:0] avs_byteenable;
  logic [STD_W-1:0] stdIn, stdOut, stdClosed;
  logic [EXT_W-1:0] extIn, extOut, extOe, swClosed;
  logic [80:1] lat;
  logic [7:0] cfg;
  string nameQ[$];
  int error_cnt, n_compared, seed;
  int pts[14] = '{1, 8, 17, 24, 25, 32, 72, 73, 80, 0, 9, 16, 81, 127};

  ebio_top ebio_top_inst(.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stdIn(stdIn), .stdOut(stdOut),
    .extIn(extIn), .extOut(extOut), .extOe(extOe));
  ebio_field_model ebio_field_model_inst(.extOut(extOut), .extOe(extOe),
    .swClosed(swClosed), .stdClosed(stdClosed), .extIn(extIn),
    .stdIn(stdIn));

  // Free-running system clock.
  always #2 clk_sys = ~clk_sys;

  task automatic cmp(string nm, logic [63:0] e, logic [63:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One access; held until waitrequest is seen low, then one idle cycle
  // so that the next access never reassigns a strobe in the same step.
  task automatic acc(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) cmp("waitrequest", 0, 1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, string nm);
    expQ.push_back(e);
    nameQ.push_back(nm);
    acc(1'b0, a, '0);
  endtask

  // Read data are valid only in the single cycle with waitrequest low.
  // They are taken at the rising edge that ends that cycle.
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (expQ.size() == 0) cmp("unexpected read", 0, 1);
      else cmp(nameQ.pop_front(), expQ.pop_front(), avs_readdata);
    end
  end

  function automatic logic pinExp(int p);
    if (p >= 1 && p <= 8) return !stdClosed[p-1];
    if (p < 17 || p > 80) return 1'b0;
    return cfg[(p-17)/8] ? lat[p] : !swClosed[p-17];
  endfunction

  task automatic chkPins();
    logic [EXT_W-1:0] eo, ee;
    for (int i = 0; i < EXT_W; i++) begin
      ee[i] = cfg[i/8];
      eo[i] = cfg[i/8] & lat[17+i];
    end
    @(negedge clk_sys);
    cmp("stdOut", lat[8:1], stdOut);
    cmp("extOut", eo, extOut);
    cmp("extOe", ee, extOe);
    @(posedge clk_sys);
  endtask

  // A command on an unknown point or an input bank leaves the latch.
  task automatic cmd(int kind, int p, logic v);
    logic ok;
    ok = (p >= 1 && p <= 8) || (p >= 17 && p <= 80 && cfg[(p-17)/8]);
    acc(1'b1, OFS_SET + 8'(4 * kind), DATA_W'(p[6:0]) | (v << ASG_VAL_BIT));
    if (ok) lat[p] = (kind == 0) ? 1'b1 : (kind == 1) ? 1'b0 : v;
    chkPins();
  endtask

  task automatic banks();
    for (int k = 0; k < BANKS; k++) begin
      logic [7:0] e;
      for (int j = 0; j < 8; j++) e[j] = pinExp(17 + 8 * k + j);
      acc(1'b1, OFS_BIDX, k + 2);
      rd(OFS_BIN, e, "bank read");
      rd(OFS_BVAR, e, "bank variable");
    end
  endtask

  initial begin
    #100us;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 0;
    rst = 1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    seed = $urandom(32'h0634);
    swClosed = {$urandom, $urandom};
    stdClosed = $urandom;
    lat = '0;
    cfg = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_CFG, 0, "cfg reset");
    rd(OFS_BIDX, 2, "bank index reset");
    rd(OFS_PIDX, 32'h11, "point index reset");
    rd(8'hFC, 0, "unmapped");
    chkPins();
    $display("test reset done");
    for (int t = 0; t < 3; t++) begin
      cfg = (t == 2) ? 8'h0F : (t == 1) ? 8'hFF : 8'($urandom) & 8'hFE;
      acc(1'b1, OFS_CFG, cfg);
      rnd = $urandom;
      acc(1'b1, OFS_STD, rnd);
      lat[8:1] = rnd[7:0];
      for (int k = 0; k < PAIRS; k++) begin
        logic [31:0] d;
        d = $urandom;
        acc(1'b1, OFS_WORD0 + 8'(4 * k), d);
        for (int b = 0; b < 2; b++)
          if (cfg[2*k+b]) lat[17+16*k+8*b +: 8] = d[8*b +: 8];
        rd(OFS_WORD0 + 8'(4 * k), lat[17+16*k +: 16], "word");
      end
      rd(OFS_CFG, cfg, "cfg");
      chkPins();
    end
    $display("test words done");
    cfg = 8'h5A;
    acc(1'b1, OFS_CFG, cfg);
    for (int k = 0; k < 3; k++)
      foreach (pts[i]) cmd(k, pts[i], 1'($urandom));
    // A set without byte lane 0 must leave the cleared point low.
    cmd(1, 25, 1'b0);
    avs_byteenable <= 4'hE;
    acc(1'b1, OFS_SET, 32'h19);
    avs_byteenable <= 4'hF;
    chkPins();
    $display("test commands done");
    banks();
    swClosed <= {$urandom, $urandom};
    repeat (4) @(posedge clk_sys);
    banks();
    $display("test bank reads done");
    foreach (pts[i]) begin
      acc(1'b1, OFS_PIDX, pts[i]);
      rd(OFS_PIN, pinExp(pts[i]), "point read");
    end
    $display("test point reads done");
    cmp("queue left", 0, expQ.size());
    summarize();
  end
endmodule
